// File: hw/cfg_load_pkg.sv
// Constants and types shared by the port configuration word loader.
// How it works
// - Word 58h bit 0 sets port 4 no-soft-reset bit, offset 44h bit 3.
// - Power-management word bits 3:1 load the port's auxiliary current field, 40h bits 24:22.
// - Word bit 4 maps to D1 support, 40h bit 25, which always reads one.
// - Word bit 5 maps to D2 support, 40h bit 26, which always reads one.
// - Word bits 7:6 load PME support for D2/D1, 40h bits 29:28.
// - Word 59h bits 15:8 load port 4 power-management data, 44h bits 31:24.
// - Port 5 uses words 5Ah and 5Bh with port 4's layout.
// - Word 60h bit 1 sets port 0 slot clock bit, D0h bit 28.
// - Port word bit 2 sets the DSI-required bit, 40h bit 21.
// - Port word bit 3 sets the LPVC count bit, 144h bit 4.
// - Port word bits 6:4 load the logical port number, CCh bits 26:24.
// - Port word bits 15:9 load the VC0 traffic-class map, 154h bits 7:1.
// - Word 62h bit 0 sets port 1 slot-implemented bit, C0h bit 24.
// - Word 62h bits 15:1 carry port 1 fields laid out as port 0.
package cfg_load_pkg;
  localparam logic [7:0] WORD_PM_P4 = 8'h58;
  localparam logic [7:0] WORD_DATA_P4 = 8'h59;
  localparam logic [7:0] WORD_PM_P5 = 8'h5a;
  localparam logic [7:0] WORD_DATA_P5 = 8'h5b;
  localparam logic [7:0] WORD_PORT_P0 = 8'h60;
  localparam logic [7:0] WORD_PORT_P1 = 8'h62;
  // Word bit positions.
  localparam int BIT_NSR = 0;
  localparam int BIT_AUX_LO = 1;
  localparam int BIT_PME_LO = 6;
  localparam int BIT_DATA_LO = 8;
  localparam int BIT_SLOT_IMPL = 0;
  localparam int BIT_SLOT_CLK = 1;
  localparam int BIT_DSI = 2;
  localparam int BIT_LPVC = 3;
  localparam int BIT_PNUM_LO = 4;
  localparam int BIT_TCMAP_LO = 9;
  // Values after reset of the loaded fields.
  localparam logic RST_NSR = 1'b0;
  localparam logic [2:0] RST_AUX = 3'h0;
  localparam logic [1:0] RST_PME = 2'h0;
  localparam logic [7:0] RST_DATA = 8'h00;
  localparam logic RST_SLOT_IMPL = 1'b0;
  localparam logic RST_SLOT_CLK = 1'b0;
  localparam logic RST_DSI = 1'b0;
  localparam logic RST_LPVC = 1'b0;
  localparam logic [2:0] RST_PNUM_P0 = 3'h0;
  localparam logic [2:0] RST_PNUM_P1 = 3'h1;
  localparam logic [6:0] RST_TCMAP = 7'h00;
  // Number of words the loader walks through.
  localparam int NUM_WORDS = 6;
  localparam logic [2:0] LAST_IDX = 3'h5;
  typedef struct packed {
    logic nsr;
    logic [2:0] aux;
    logic [1:0] pme;
    logic [7:0] data;
  } pm_fields_t;
  typedef struct packed {
    logic slot_impl;
    logic slot_clk;
    logic dsi;
    logic lpvc;
    logic [2:0] pnum;
    logic [6:0] tcmap;
  } port_fields_t;
endpackage

// File: hw/mem_read_if.sv
// Request and answer between the loader sequencer and the memory port fetcher.
`timescale 1ns/1ns
`default_nettype none
interface mem_read_if;
  logic req;
  logic [7:0] addr;
  logic done;
  logic present;
  logic [15:0] data;
  modport seq (output req, output addr, input done, input present, input data);
  modport fetch (input req, input addr, output done, output present, output data);
endinterface
`default_nettype wire

// File: hw/word_fetch.sv
// Fetches one 16-bit word from the external memory port per request.
`timescale 1ns/1ns
`default_nettype none
module word_fetch (
  input wire logic clock,
  input wire logic rst_n,
  mem_read_if.fetch rd,
  output logic mem_rd,
  output logic [7:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_valid,
  input wire logic [15:0] mem_data
);
  typedef struct packed {
    logic busy;
    logic rd;
    logic [7:0] addr;
    logic done;
    logic present;
    logic [15:0] data;
  } fetch_state_t;
  fetch_state_t st_reg;
  fetch_state_t st_next;

  // A request is held open until the memory acknowledges it.
  always_comb begin
    st_next = st_reg;
    st_next.done = 1'b0;
    if (!st_reg.busy && rd.req) begin
      st_next.busy = 1'b1;
      st_next.rd = 1'b1;
      st_next.addr = rd.addr;
    end else if (st_reg.busy && mem_ack) begin
      st_next.busy = 1'b0;
      st_next.rd = 1'b0;
      st_next.done = 1'b1;
      st_next.present = mem_valid;
      st_next.data = mem_data;
    end
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign mem_rd = st_reg.rd;
  assign mem_addr = st_reg.addr;
  assign rd.done = st_reg.done;
  assign rd.present = st_reg.present;
  assign rd.data = st_reg.data;
endmodule
`default_nettype wire

// File: hw/port_config_word_loader.sv
// Loads power-management and port configuration fields from the configuration memory.
`timescale 1ns/1ns
`default_nettype none
module port_config_word_loader (
  input wire logic clock,
  input wire logic rstn,
  output logic mem_rd,
  output logic [7:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_valid,
  input wire logic [15:0] mem_data,
  output logic load_done,
  output logic p4_no_soft_reset,
  output logic [2:0] p4_aux_current,
  output logic p4_d1_support,
  output logic p4_d2_support,
  output logic [1:0] p4_pme_d2d1,
  output logic [7:0] p4_pm_data,
  output logic p5_no_soft_reset,
  output logic [2:0] p5_aux_current,
  output logic p5_d1_support,
  output logic p5_d2_support,
  output logic [1:0] p5_pme_d2d1,
  output logic [7:0] p5_pm_data,
  output logic p0_slot_clock,
  output logic p0_dsi_required,
  output logic p0_lpvc_count,
  output logic [2:0] p0_port_number,
  output logic [6:0] p0_vc0_tc_map,
  output logic p1_slot_implemented,
  output logic p1_slot_clock,
  output logic p1_dsi_required,
  output logic p1_lpvc_count,
  output logic [2:0] p1_port_number,
  output logic [6:0] p1_vc0_tc_map
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_REQ = 4'h2,
    ST_WAIT = 4'h4,
    ST_DONE = 4'h8
  } seq_state_t;

  typedef struct packed {
    seq_state_t st;
    logic [2:0] idx;
    logic done;
    cfg_load_pkg::pm_fields_t p4;
    cfg_load_pkg::pm_fields_t p5;
    cfg_load_pkg::port_fields_t p0;
    cfg_load_pkg::port_fields_t p1;
  } loader_state_t;

  loader_state_t s_reg;
  loader_state_t s_next;
  logic [1:0] rst_sync_reg;
  logic rst_n;
  mem_read_if rd ();

  // Word address for each step of the load sequence.
  function automatic logic [7:0] word_addr(input logic [2:0] idx);
    unique case (idx)
      3'h0: word_addr = cfg_load_pkg::WORD_PM_P4;
      3'h1: word_addr = cfg_load_pkg::WORD_DATA_P4;
      3'h2: word_addr = cfg_load_pkg::WORD_PM_P5;
      3'h3: word_addr = cfg_load_pkg::WORD_DATA_P5;
      3'h4: word_addr = cfg_load_pkg::WORD_PORT_P0;
      default: word_addr = cfg_load_pkg::WORD_PORT_P1;
    endcase
  endfunction

  // Capability word: no-soft-reset, auxiliary current and PME support.
  function automatic cfg_load_pkg::pm_fields_t load_pm(input cfg_load_pkg::pm_fields_t f,
                                                       input logic [15:0] w);
    cfg_load_pkg::pm_fields_t r;
    r = f;
    r.nsr = w[cfg_load_pkg::BIT_NSR];
    r.aux = w[cfg_load_pkg::BIT_AUX_LO +: 3];
    r.pme = w[cfg_load_pkg::BIT_PME_LO +: 2];
    return r;
  endfunction

  // Port word; slot-implemented is taken only for port 1.
  function automatic cfg_load_pkg::port_fields_t load_port(input cfg_load_pkg::port_fields_t f,
                                                           input logic [15:0] w,
                                                           input logic take_slot);
    cfg_load_pkg::port_fields_t r;
    r = f;
    if (take_slot) begin
      r.slot_impl = w[cfg_load_pkg::BIT_SLOT_IMPL];
    end
    r.slot_clk = w[cfg_load_pkg::BIT_SLOT_CLK];
    r.dsi = w[cfg_load_pkg::BIT_DSI];
    r.lpvc = w[cfg_load_pkg::BIT_LPVC];
    r.pnum = w[cfg_load_pkg::BIT_PNUM_LO +: 3];
    r.tcmap = w[cfg_load_pkg::BIT_TCMAP_LO +: 7];
    return r;
  endfunction

  assign rst_n = rst_sync_reg[1];

  word_fetch u_fetch (
    .clock(clock),
    .rst_n(rst_n),
    .rd(rd.fetch),
    .mem_rd(mem_rd),
    .mem_addr(mem_addr),
    .mem_ack(mem_ack),
    .mem_valid(mem_valid),
    .mem_data(mem_data)
  );

  assign rd.req = (s_reg.st == ST_REQ);
  assign rd.addr = word_addr(s_reg.idx);

  // Sequencer walks every word once after reset; absent words leave defaults.
  always_comb begin
    s_next = s_reg;
    unique case (s_reg.st)
      ST_IDLE: begin
        s_next.st = ST_REQ;
      end
      ST_REQ: begin
        s_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        if (rd.done) begin
          if (rd.present) begin
            unique case (s_reg.idx)
              3'h0: s_next.p4 = load_pm(s_reg.p4, rd.data);
              3'h1: s_next.p4.data = rd.data[cfg_load_pkg::BIT_DATA_LO +: 8];
              3'h2: s_next.p5 = load_pm(s_reg.p5, rd.data);
              3'h3: s_next.p5.data = rd.data[cfg_load_pkg::BIT_DATA_LO +: 8];
              3'h4: s_next.p0 = load_port(s_reg.p0, rd.data, 1'b0);
              default: s_next.p1 = load_port(s_reg.p1, rd.data, 1'b1);
            endcase
          end
          if (s_reg.idx == cfg_load_pkg::LAST_IDX) begin
            s_next.st = ST_DONE;
            s_next.done = 1'b1;
          end else begin
            s_next.idx = s_reg.idx + 3'h1;
            s_next.st = ST_REQ;
          end
        end
      end
      ST_DONE: begin
        s_next.st = ST_DONE;
      end
      default: begin
        s_next.st = ST_IDLE;
      end
    endcase
  end

  // The reset synchroniser runs on the raw reset, so it lives apart from the state struct.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // Loader state and loaded fields.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_reg.st <= ST_IDLE;
      s_reg.idx <= 3'h0;
      s_reg.done <= 1'b0;
      s_reg.p4 <= {cfg_load_pkg::RST_NSR, cfg_load_pkg::RST_AUX, cfg_load_pkg::RST_PME,
                   cfg_load_pkg::RST_DATA};
      s_reg.p5 <= {cfg_load_pkg::RST_NSR, cfg_load_pkg::RST_AUX, cfg_load_pkg::RST_PME,
                   cfg_load_pkg::RST_DATA};
      s_reg.p0 <= {cfg_load_pkg::RST_SLOT_IMPL, cfg_load_pkg::RST_SLOT_CLK, cfg_load_pkg::RST_DSI,
                   cfg_load_pkg::RST_LPVC, cfg_load_pkg::RST_PNUM_P0, cfg_load_pkg::RST_TCMAP};
      s_reg.p1 <= {cfg_load_pkg::RST_SLOT_IMPL, cfg_load_pkg::RST_SLOT_CLK, cfg_load_pkg::RST_DSI,
                   cfg_load_pkg::RST_LPVC, cfg_load_pkg::RST_PNUM_P1, cfg_load_pkg::RST_TCMAP};
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs come straight from the state flip-flops; D1/D2 support are fixed ones.
  assign load_done = s_reg.done;
  assign p4_no_soft_reset = s_reg.p4.nsr;
  assign p4_aux_current = s_reg.p4.aux;
  assign p4_d1_support = 1'b1;
  assign p4_d2_support = 1'b1;
  assign p4_pme_d2d1 = s_reg.p4.pme;
  assign p4_pm_data = s_reg.p4.data;
  assign p5_no_soft_reset = s_reg.p5.nsr;
  assign p5_aux_current = s_reg.p5.aux;
  assign p5_d1_support = 1'b1;
  assign p5_d2_support = 1'b1;
  assign p5_pme_d2d1 = s_reg.p5.pme;
  assign p5_pm_data = s_reg.p5.data;
  assign p0_slot_clock = s_reg.p0.slot_clk;
  assign p0_dsi_required = s_reg.p0.dsi;
  assign p0_lpvc_count = s_reg.p0.lpvc;
  assign p0_port_number = s_reg.p0.pnum;
  assign p0_vc0_tc_map = s_reg.p0.tcmap;
  assign p1_slot_implemented = s_reg.p1.slot_impl;
  assign p1_slot_clock = s_reg.p1.slot_clk;
  assign p1_dsi_required = s_reg.p1.dsi;
  assign p1_lpvc_count = s_reg.p1.lpvc;
  assign p1_port_number = s_reg.p1.pnum;
  assign p1_vc0_tc_map = s_reg.p1.tcmap;

  // Port 4 capability fields follow word 58h one cycle after its answer.
  AST_P4_PM_LOAD: assert property (@(posedge clock)
    disable iff (!rst_n)
    (s_reg.st == ST_WAIT && rd.done && rd.present && s_reg.idx == 3'h0) |=>
    (p4_no_soft_reset == $past(rd.data[0]) && p4_aux_current == $past(rd.data[3:1])
     && p4_pme_d2d1 == $past(rd.data[7:6])))
    else $error("Port 4 capability word not loaded.");
  // D1 and D2 support never read as zero.
  AST_D1D2_ONE: assert property (@(posedge clock)
    disable iff (!rst_n)
    p4_d1_support && p4_d2_support && p5_d1_support && p5_d2_support)
    else $error("D1 or D2 support read as zero.");
  // Port 4 data byte follows word 59h.
  AST_P4_DATA: assert property (@(posedge clock)
    disable iff (!rst_n)
    (s_reg.st == ST_WAIT && rd.done && rd.present && s_reg.idx == 3'h1) |=>
    p4_pm_data == $past(rd.data[15:8]))
    else $error("Port 4 data byte not loaded.");
  // Port 5 data byte follows word 5Bh, and port 4's data byte holds.
  AST_P5_LOAD: assert property (@(posedge clock)
    disable iff (!rst_n)
    (s_reg.st == ST_WAIT && rd.done && rd.present && s_reg.idx == 3'h3) |=>
    p5_pm_data == $past(rd.data[15:8]) && $stable(p4_pm_data))
    else $error("Port 5 data byte not loaded.");
  // Port 0 word fields land in place.
  AST_P0_LOAD: assert property (@(posedge clock)
    disable iff (!rst_n)
    (s_reg.st == ST_WAIT && rd.done && rd.present && s_reg.idx == 3'h4) |=>
    (p0_slot_clock == $past(rd.data[1]) && p0_dsi_required == $past(rd.data[2])
     && p0_lpvc_count == $past(rd.data[3]) && p0_port_number == $past(rd.data[6:4])
     && p0_vc0_tc_map == $past(rd.data[15:9])))
    else $error("Port 0 word not loaded.");
  // Port 1 word, slot-implemented included.
  AST_P1_LOAD: assert property (@(posedge clock)
    disable iff (!rst_n)
    (s_reg.st == ST_WAIT && rd.done && rd.present && s_reg.idx == 3'h5) |=>
    (p1_slot_implemented == $past(rd.data[0]) && p1_vc0_tc_map == $past(rd.data[15:9])
     && p1_port_number == $past(rd.data[6:4]) && load_done))
    else $error("Port 1 word not loaded.");
  // An absent word leaves fields untouched.
  AST_ABSENT_KEEP: assert property (@(posedge clock)
    disable iff (!rst_n)
    (rd.done && !rd.present) |=> $stable(p0_vc0_tc_map) && $stable(p4_pm_data)
    && $stable(p1_port_number))
    else $error("Absent word changed a field.");
  // Done only rises once the last word was answered, and then holds for four more cycles.
  AST_DONE_HOLD: assert property (@(posedge clock)
    disable iff (!rst_n)
    $rose(load_done) |-> $past(s_reg.idx) == 3'h5 ##1 load_done [*4])
    else $error("Load done rose early or dropped.");
endmodule
`default_nettype wire

// File: sim/cfg_mem_model.sv
// Behavioural configuration memory that answers the loader's word reads.
`timescale 1ns/1ns
`default_nettype none
module cfg_mem_model (
  input wire logic clock,
  input wire logic mem_rd,
  input wire logic [7:0] mem_addr,
  output logic mem_ack,
  output logic mem_valid,
  output logic [15:0] mem_data
);
  logic [15:0] words [0:255];
  logic present [0:255];
  int lat;
  int wait_cnt;
  logic [7:0] seen [$];
  // Idle answer lines; words, presence and latency are set by the bench before each load,
  // so nothing here may overwrite them at time zero.
  initial begin
    mem_ack = 1'b0;
    mem_valid = 1'b0;
    mem_data = 16'h0000;
  end
  // Answers a held read after lat idle cycles with a one-cycle ack; outside the ack
  // the data lines show the inverse of the last word, so stale data is never mistaken.
  always @(posedge clock) begin
    #1;
    if (mem_ack) begin
      mem_ack = 1'b0;
      mem_valid = 1'b0;
      mem_data = ~mem_data;
    end else if (mem_rd) begin
      if (wait_cnt >= lat) begin
        mem_ack = 1'b1;
        mem_valid = present[mem_addr];
        mem_data = words[mem_addr];
        seen.push_back(mem_addr);
        wait_cnt = 0;
      end else begin
        wait_cnt++;
      end
    end
  end
endmodule
`default_nettype wire

// File: sim/port_config_word_loader_tb_top.sv
// Self-checking bench for the port configuration word loader.
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected %s expected %0h seen %0h", name, exp, got); end end
module port_config_word_loader_tb_top;
  logic clock, rstn, mem_rd, mem_ack, mem_valid, load_done;
  logic [7:0] mem_addr, p4_pm_data, p5_pm_data;
  logic [15:0] mem_data;
  logic p4_no_soft_reset, p4_d1_support, p4_d2_support;
  logic p5_no_soft_reset, p5_d1_support, p5_d2_support;
  logic [2:0] p4_aux_current, p5_aux_current, p0_port_number, p1_port_number;
  logic [1:0] p4_pme_d2d1, p5_pme_d2d1;
  logic p0_slot_clock, p0_dsi_required, p0_lpvc_count, p1_slot_implemented;
  logic p1_slot_clock, p1_dsi_required, p1_lpvc_count;
  logic [6:0] p0_vc0_tc_map, p1_vc0_tc_map;
  int err_total = 0;
  int num_checks = 0;
  port_config_word_loader dut (.*);
  cfg_mem_model mem (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_ack(mem_ack), .mem_valid(mem_valid), .mem_data(mem_data));
  // Free-running 100 MHz clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Holds reset for 12 cycles and checks the defaults of every port 4, port 5 and port 0 field and of port 1's number.
  task automatic do_reset();
    @(posedge clock);
    #1 rstn = 1'b0;
    repeat (12) @(posedge clock);
    #1;
    `CHK("rst_done", 1'b0, load_done)
    `CHK("rst_rd", 1'b0, mem_rd)
    `CHK("rst_p4", 14'h0000, {p4_no_soft_reset, p4_aux_current, p4_pme_d2d1, p4_pm_data})
    `CHK("rst_p5", 14'h0000, {p5_no_soft_reset, p5_aux_current, p5_pme_d2d1, p5_pm_data})
    `CHK("rst_d1d2", 4'hf, {p4_d1_support, p4_d2_support, p5_d1_support, p5_d2_support})
    `CHK("rst_p0", 13'h0000, {p0_slot_clock, p0_dsi_required, p0_lpvc_count, p0_port_number,
      p0_vc0_tc_map})
    `CHK("rst_p1_num", 3'h1, p1_port_number)
    mem.seen.delete();
    rstn = 1'b1;
  endtask
  // Programs six words, reloads them after reset and checks every loaded field.
  task automatic run_load(input logic [15:0] w0, w1, w2, w3, w4, w5,
                          input logic [5:0] pr, input int lat);
    logic [15:0] g [6];
    logic [7:0] ad [6];
    int n;
    g = '{w0, w1, w2, w3, w4, w5};
    ad = '{8'h58, 8'h59, 8'h5a, 8'h5b, 8'h60, 8'h62};
    mem.lat = lat;
    for (int i = 0; i < 6; i++) begin
      mem.words[ad[i]] = g[i];
      mem.present[ad[i]] = pr[i];
      if (!pr[i]) begin
        g[i] = 16'h0000;
      end
    end
    do_reset();
    n = 0;
    while (load_done !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    #2;
    `CHK("load_done", 1'b1, load_done)
    `CHK("reads", 6, mem.seen.size())
    for (int i = 0; i < 6; i++) begin
      `CHK("addr", ad[i], mem.seen[i])
    end
    `CHK("p4_nsr", g[0][0], p4_no_soft_reset)
    `CHK("p4_aux", g[0][3:1], p4_aux_current)
    `CHK("p4_d1", 1'b1, p4_d1_support)
    `CHK("p4_d2", 1'b1, p4_d2_support)
    `CHK("p4_pme", g[0][7:6], p4_pme_d2d1)
    `CHK("p4_data", g[1][15:8], p4_pm_data)
    `CHK("p5_pm", {g[2][0], g[2][3:1], g[2][7:6]}, {p5_no_soft_reset, p5_aux_current,
      p5_pme_d2d1})
    `CHK("p5_d1d2", 2'h3, {p5_d1_support, p5_d2_support})
    `CHK("p5_data", g[3][15:8], p5_pm_data)
    `CHK("p0_clk", g[4][1], p0_slot_clock)
    `CHK("p0_dsi", g[4][2], p0_dsi_required)
    `CHK("p0_lpvc", g[4][3], p0_lpvc_count)
    `CHK("p0_num", g[4][6:4], p0_port_number)
    `CHK("p0_tc", g[4][15:9], p0_vc0_tc_map)
    `CHK("p1_slot", g[5][0], p1_slot_implemented)
    `CHK("p1_bits", g[5][3:1], {p1_lpvc_count, p1_dsi_required, p1_slot_clock})
    `CHK("p1_tc", g[5][15:9], p1_vc0_tc_map)
    `CHK("p1_num", pr[5] ? g[5][6:4] : 3'h1, p1_port_number)
  endtask
  // Distinct patterns, all words present, prompt memory.
  task automatic s_prompt();
    run_load(16'h12c5, 16'ha7ff, 16'hfe3a, 16'h5c00, 16'hb6d5, 16'h4f2a, 6'h3f, 0);
  endtask
  // All ones from a slow memory, so every field and every stalled read is exercised.
  task automatic s_slow_ones();
    run_load(16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 6'h3f, 4);
  endtask
  // Alternate words unprogrammed: those fields must keep their defaults.
  task automatic s_absent();
    run_load(16'hffff, 16'hffff, 16'haaaa, 16'h5555, 16'hffff, 16'hffff, 6'h2a, 1);
  endtask
  // Inverse layout, last word absent, after a reset taken from a load with alternate words absent.
  task automatic s_inverse();
    run_load(16'h5555, 16'haaaa, 16'h0000, 16'hfe01, 16'h5555, 16'haaaa, 6'h1f, 2);
  endtask
  // Main sequence.
  initial begin
    rstn = 1'b0;
    s_prompt();
    s_slow_ones();
    s_absent();
    s_inverse();
    s_slow_ones();
    final_report();
  end
  // Watchdog, well beyond the few hundred cycles the scenarios need.
  initial begin
    #200000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
